// *** hw/eeprom_pkg.sv ***
/*
  Shared constants for the serial EEPROM command engine: frame layout,
  instruction codes, clock counts, reset values and write timing.
  Assumes a 100 MHz system clock and a 16-bit word, 10-bit address array.
*/
package eeprom_pkg;

  // ----------------------------------------------------------------
  // array and frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 16;
  localparam int MEM_WORDS = 1 << ADDR_W;
  localparam int FIELD_W   = 2 + ADDR_W + DATA_W;   // opcode, address, data
  localparam int CNT_W     = 6;
  localparam int HDR_W     = 4;                     // opcode plus two top address bits
  localparam int BIDX_W    = 4;

  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  // clocks after the start bit
  localparam logic [CNT_W-1:0] HDR_CLKS   = 6'h04;
  localparam logic [CNT_W-1:0] SHORT_CLKS = 6'h0C;  // opcode plus address
  localparam logic [CNT_W-1:0] LONG_CLKS  = 6'h1C;  // plus one data word
  localparam logic [CNT_W-1:0] CNT_MAX    = 6'h3F;
  localparam logic [BIDX_W-1:0] BIDX_LAST = 4'hF;

  // field positions inside the frame shifter
  localparam int OP_LONG_HI  = FIELD_W - 1;
  localparam int ADDR_LONG_HI = FIELD_W - 3;
  localparam int ADDR_SHORT_HI = ADDR_W - 1;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRALL   = 2'h1;
  localparam logic [1:0] SUB_ERALL   = 2'h2;
  localparam logic [1:0] SUB_ENABLE  = 2'h3;

  typedef enum logic [2:0] {
    CMD_NONE    = 3'b000,
    CMD_WRITE   = 3'b001,
    CMD_ERASE   = 3'b010,
    CMD_WRALL   = 3'b011,
    CMD_ERALL   = 3'b100,
    CMD_ENABLE  = 3'b101,
    CMD_DISABLE = 3'b110
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETTLE  = 2'b01,
    ST_WRITING = 2'b10
  } eng_state_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_PS    = 10000;
  localparam longint WRITE_TYP_US     = 2000;
  localparam longint WRITE_MAX_US     = 4000;
  localparam int     WRITE_CYCLES_DEF = int'((WRITE_TYP_US * 1000000) / CLK_PERIOD_PS);
  localparam int     WRITE_MAX_CYCLES = int'((WRITE_MAX_US * 1000000) / CLK_PERIOD_PS);
  localparam logic [1:0] SETTLE_LAST  = 2'h3;       // held frame settles after deselect

endpackage

// *** hw/write_timer.sv ***
/*
  Cell write timer: runs for a fixed number of system clocks once started.
  Assumes start and abort come from logic on the same clock.
*/
`timescale 1ns/1ps
module write_timer
  import eeprom_pkg::*;
#(
  parameter int CYCLES = WRITE_CYCLES_DEF
)
(
  // system
  input  wire logic i_clk,
  input  wire logic i_srst,
  // control
  input  wire logic i_start,
  input  wire logic i_abort,
  // status
  output logic      o_busy,
  output logic      o_done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          busy_r;
  logic          busy_nxt;
  logic          done_r;
  logic          done_nxt;

  // abort wins over everything, start only counts when idle
  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (i_abort)
    begin
      busy_nxt = 1'b0;
      cnt_nxt  = '0;
    end
    else if (busy_r)
    begin
      if (cnt_r == LAST)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        cnt_nxt  = '0;
      end
      else
        cnt_nxt = cnt_r + 1'b1;
    end
    else if (i_start)
      busy_nxt = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;

endmodule

// *** hw/serial_eeprom_command_engine.sv ***
/*
  Command engine of a 16-bit-word serial EEPROM with chip select, serial
  clock, serial in and a tri-state serial out. The link logic runs on the
  serial clock; the array, write timing and the output pin run on i_clk.
  Assumes the serial clock period is at least four i_clk periods and that
  the serial clock stands still while chip select is low.
*/
// How it works
// - array resets to all ones
// - bits taken on rising serial clock
// - chip select low means standby
// - dummy low clocks precede the start bit
// - read drives low, then shifts word
// - continued clocking reads next word, wrapping
// - write starts at deselect, inputs ignored
// - writes need program enable mode
// - cell write ends within maximum time
// - verify shows low busy, high ready
// - start bit during verify floats output
// - single write programs one word
// - single erase sets one word ones
// - write all programs every word
// - erase all sets whole array ones
// - wrong clock count cancels writes
// - enable or disable at deselect
// - low supply forces program disable
`timescale 1ns/1ps
module serial_eeprom_command_engine
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)
(
  // system
  input  wire logic i_clk,
  input  wire logic i_srst,
  // serial link
  input  wire logic i_serial_clock,
  input  wire logic i_chip_select,
  input  wire logic i_serial_in,
  output logic      o_serial_out,
  output logic      o_serial_out_oe,
  // supply detector
  input  wire logic i_supply_low
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // link domain, cleared while deselected
  logic                started_r, started_nxt;
  logic [CNT_W-1:0]    cnt_r, cnt_nxt;
  logic                reading_r, reading_nxt;
  logic [BIDX_W-1:0]   bidx_r, bidx_nxt;
  logic [DATA_W-1:0]   osh_r, osh_nxt;
  logic                obit_r, obit_nxt;
  logic                ooe_r, ooe_nxt;
  // link domain, held across deselect
  logic [CNT_W-1:0]    h_cnt_r, h_cnt_nxt;
  logic [FIELD_W-1:0]  h_sh_r, h_sh_nxt;
  logic [HDR_W-1:0]    h_hdr_r, h_hdr_nxt;
  logic [ADDR_W-1:0]   rd_addr_r, rd_addr_nxt;
  logic                rd_tog_r, rd_tog_nxt;
  logic                busy_lm_r, busy_lk_r;
  // system domain
  localparam int NSYNC = 6;
  logic [NSYNC-1:0]    sync1_r, sync2_r;
  logic                cs_s, start_s, ooe_s, obit_s, rtog_s, low_s;
  eng_state_t          st_r, st_nxt;
  logic [1:0]          settle_r, settle_nxt;
  logic                cs_d_r, start_d_r, rtog_d_r;
  logic                seen_start_r, seen_start_nxt;
  logic                verify_arm_r, verify_arm_nxt;
  logic                wen_r, wen_nxt;
  logic [ADDR_W-1:0]   pend_addr_r, pend_addr_nxt;
  logic [DATA_W-1:0]   pend_val_r, pend_val_nxt;
  logic                pend_all_r, pend_all_nxt;
  logic [DATA_W-1:0]   rd_word_r, rd_word_nxt;
  logic                do_nxt, do_oe_nxt;
  logic                t_start, t_abort, t_busy, t_done, commit;
  logic [DATA_W-1:0]   mem_r [MEM_WORDS];
  cmd_t                cmd;

  // ----------------------------------------------------------------
  // link side: framing and read-out
  // ----------------------------------------------------------------
  // sampling on rising edge
  always_comb
  begin
    started_nxt = started_r;
    cnt_nxt     = cnt_r;
    reading_nxt = reading_r;
    bidx_nxt    = bidx_r;
    osh_nxt     = osh_r;
    obit_nxt    = obit_r;
    ooe_nxt     = ooe_r;
    h_cnt_nxt   = h_cnt_r;
    h_sh_nxt    = h_sh_r;
    h_hdr_nxt   = h_hdr_r;
    rd_addr_nxt = rd_addr_r;
    rd_tog_nxt  = rd_tog_r;
    if (!started_r)
    begin
      if (i_serial_in && !busy_lk_r)
      begin
        started_nxt = 1'b1;
        // toggle has no reset; give it a known level at every start bit
        rd_tog_nxt  = 1'b0;
        h_cnt_nxt   = '0;
        h_sh_nxt    = '0;
        h_hdr_nxt   = '0;
      end
    end
    else if (reading_r)
    begin
      // first bit of each word from fetched copy
      if (bidx_r == '0)
      begin
        obit_nxt = rd_word_r[DATA_W-1];
        osh_nxt  = {rd_word_r[DATA_W-2:0], 1'b0};
        bidx_nxt = bidx_r + 1'b1;
      end
      else
      begin
        obit_nxt = osh_r[DATA_W-1];
        osh_nxt  = {osh_r[DATA_W-2:0], 1'b0};
        bidx_nxt = bidx_r + 1'b1;
        if (bidx_r == BIDX_LAST)
        begin
          rd_addr_nxt = rd_addr_r + 1'b1;
          rd_tog_nxt  = !rd_tog_r;
        end
      end
    end
    else
    begin
      // count saturates so overcount stays visible
      cnt_nxt   = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 1'b1;
      h_sh_nxt  = {h_sh_r[FIELD_W-2:0], i_serial_in};
      h_cnt_nxt = cnt_nxt;
      if (cnt_nxt == HDR_CLKS)
        h_hdr_nxt = h_sh_nxt[HDR_W-1:0];
      // drive low after last address bit
      if (cnt_nxt == SHORT_CLKS && h_hdr_r[3:2] == OP_READ)
      begin
        reading_nxt = 1'b1;
        ooe_nxt     = 1'b1;
        obit_nxt    = 1'b0;
        bidx_nxt    = '0;
        rd_addr_nxt = h_sh_nxt[ADDR_SHORT_HI:0];
        rd_tog_nxt  = !rd_tog_r;
      end
    end
  end

  always_ff @(posedge i_serial_clock or negedge i_chip_select)
  begin
    if (!i_chip_select)
    begin
      started_r <= 1'b0;
      cnt_r     <= '0;
      reading_r <= 1'b0;
      bidx_r    <= '0;
      osh_r     <= '0;
      obit_r    <= 1'b0;
      ooe_r     <= 1'b0;
    end
    else
    begin
      started_r <= started_nxt;
      cnt_r     <= cnt_nxt;
      reading_r <= reading_nxt;
      bidx_r    <= bidx_nxt;
      osh_r     <= osh_nxt;
      obit_r    <= obit_nxt;
      ooe_r     <= ooe_nxt;
    end
  end

  // held frame survives deselect so the system side can decode it
  always_ff @(posedge i_serial_clock)
  begin
    h_cnt_r   <= h_cnt_nxt;
    h_sh_r    <= h_sh_nxt;
    h_hdr_r   <= h_hdr_nxt;
    rd_addr_r <= rd_addr_nxt;
    rd_tog_r  <= rd_tog_nxt;
    busy_lm_r <= t_busy;
    busy_lk_r <= busy_lm_r;
  end

  // ----------------------------------------------------------------
  // crossing into the system clock
  // ----------------------------------------------------------------
  // two flops per level; only the second stage is read
  always_ff @(posedge i_clk)
  begin
    sync1_r <= {i_chip_select, started_r, ooe_r, obit_r, rd_tog_r, i_supply_low};
    sync2_r <= sync1_r;
  end
  assign {cs_s, start_s, ooe_s, obit_s, rtog_s, low_s} = sync2_r;

  // ----------------------------------------------------------------
  // instruction decode at deselect
  // ----------------------------------------------------------------
  function automatic cmd_t decode_cmd(input logic [CNT_W-1:0] cnt,
                                      input logic [HDR_W-1:0] hdr);
    cmd_t c;
    c = CMD_NONE;
    case (hdr[3:2])
      OP_WRITE: c = (cnt == LONG_CLKS) ? CMD_WRITE : CMD_NONE;
      OP_ERASE: c = (cnt == SHORT_CLKS) ? CMD_ERASE : CMD_NONE;
      OP_EXT:
        if (cnt >= HDR_CLKS)
        begin
          case (hdr[1:0])
            SUB_WRALL:   c = (cnt == LONG_CLKS) ? CMD_WRALL : CMD_NONE;
            SUB_ERALL:   c = (cnt == SHORT_CLKS) ? CMD_ERALL : CMD_NONE;
            SUB_ENABLE:  c = (cnt <= SHORT_CLKS) ? CMD_ENABLE : CMD_NONE;
            SUB_DISABLE: c = (cnt <= SHORT_CLKS) ? CMD_DISABLE : CMD_NONE;
            default:     c = CMD_NONE;
          endcase
        end
      default:  c = CMD_NONE;
    endcase
    return c;
  endfunction

  // held frame is stable once the link clock has stopped
  assign cmd = decode_cmd(h_cnt_r, h_hdr_r);

  // ----------------------------------------------------------------
  // engine: decode, write start, verify and output pin
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt         = st_r;
    settle_nxt     = settle_r;
    seen_start_nxt = seen_start_r;
    verify_arm_nxt = verify_arm_r;
    wen_nxt        = wen_r;
    pend_addr_nxt  = pend_addr_r;
    pend_val_nxt   = pend_val_r;
    pend_all_nxt   = pend_all_r;
    t_start        = 1'b0;
    t_abort        = 1'b0;
    commit         = 1'b0;
    if (cs_s && start_s)
      seen_start_nxt = 1'b1;
    // a new start bit ends verify
    if (start_s && !start_d_r)
      verify_arm_nxt = 1'b0;
    case (st_r)
      ST_IDLE:
        if (cs_d_r && !cs_s)
        begin
          seen_start_nxt = 1'b0;
          settle_nxt     = '0;
          if (seen_start_r)
            st_nxt = ST_SETTLE;
        end
      ST_SETTLE:
      begin
        settle_nxt = settle_r + 1'b1;
        if (settle_r == SETTLE_LAST)
        begin
          st_nxt        = ST_IDLE;
          pend_all_nxt  = (cmd == CMD_WRALL) || (cmd == CMD_ERALL);
          pend_addr_nxt = (cmd == CMD_WRITE) ? h_sh_r[ADDR_LONG_HI -: ADDR_W]
                                             : h_sh_r[ADDR_SHORT_HI:0];
          // write all keeps the data word
          pend_val_nxt  = (cmd == CMD_WRITE || cmd == CMD_WRALL) ? h_sh_r[DATA_W-1:0]
                                                                 : ERASED_WORD;
          if (cmd == CMD_ENABLE)
            wen_nxt = 1'b1;
          if (cmd == CMD_DISABLE)
            wen_nxt = 1'b0;
          if (cmd inside {CMD_WRITE, CMD_ERASE, CMD_WRALL, CMD_ERALL} && wen_r && !low_s)
          begin
            t_start        = 1'b1;
            verify_arm_nxt = 1'b1;
            st_nxt         = ST_WRITING;
          end
        end
      end
      ST_WRITING:
        if (low_s)
        begin
          t_abort = 1'b1;
          st_nxt  = ST_IDLE;
        end
        else if (t_done)
        begin
          commit = 1'b1;
          st_nxt = ST_IDLE;
        end
      default:
        st_nxt = ST_IDLE;
    endcase
    if (low_s)
      wen_nxt = 1'b0;
  end

  // float except read data and verify
  always_comb
  begin
    do_oe_nxt = cs_s && (ooe_s || (verify_arm_r && !start_s));
    do_nxt    = ooe_s ? obit_s : !t_busy;
  end

  // read fetch on each address toggle from the link
  always_comb
  begin
    rd_word_nxt = rd_word_r;
    if (rtog_s != rtog_d_r)
      rd_word_nxt = mem_r[rd_addr_r];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_r            <= ST_IDLE;
      settle_r        <= '0;
      cs_d_r          <= 1'b0;
      start_d_r       <= 1'b0;
      rtog_d_r        <= 1'b0;
      seen_start_r    <= 1'b0;
      verify_arm_r    <= 1'b0;
      wen_r           <= 1'b0;
      pend_addr_r     <= '0;
      pend_val_r      <= ERASED_WORD;
      pend_all_r      <= 1'b0;
      rd_word_r       <= ERASED_WORD;
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end
    else
    begin
      st_r            <= st_nxt;
      settle_r        <= settle_nxt;
      cs_d_r          <= cs_s;
      start_d_r       <= start_s;
      rtog_d_r        <= rtog_s;
      seen_start_r    <= seen_start_nxt;
      verify_arm_r    <= verify_arm_nxt;
      wen_r           <= wen_nxt;
      pend_addr_r     <= pend_addr_nxt;
      pend_val_r      <= pend_val_nxt;
      pend_all_r      <= pend_all_nxt;
      rd_word_r       <= rd_word_nxt;
      o_serial_out    <= do_nxt;
      o_serial_out_oe <= do_oe_nxt;
    end
  end

  write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_start (t_start),
    .i_abort (t_abort),
    .o_busy  (t_busy),
    .o_done  (t_done)
  );

  // ----------------------------------------------------------------
  // array: one word register per address
  // ----------------------------------------------------------------
  // delivered state is all ones
  for (genvar gi = 0; gi < MEM_WORDS; gi++)
  begin : g_word
    always_ff @(posedge i_clk)
    begin
      if (i_srst)
        mem_r[gi] <= ERASED_WORD;
      else if (commit && (pend_all_r || pend_addr_r == ADDR_W'(gi)))
        mem_r[gi] <= pend_val_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  int unsigned busy_len_r;
  always_ff @(posedge i_clk)
    busy_len_r <= (i_srst || !t_busy) ? 0 : busy_len_r + 1;

  a_standby_float: assert property (@(posedge i_clk) disable iff (i_srst)
    !cs_s |=> !o_serial_out_oe) else $error("output driven while deselected");
  a_verify_busy: assert property (@(posedge i_clk) disable iff (i_srst)
    cs_s && verify_arm_r && !start_s && !ooe_s && t_busy |=> o_serial_out_oe && !o_serial_out)
    else $error("busy not shown low during verify");
  a_verify_ready: assert property (@(posedge i_clk) disable iff (i_srst)
    cs_s && verify_arm_r && !start_s && !ooe_s && !t_busy |=> o_serial_out_oe && o_serial_out)
    else $error("ready not shown high during verify");
  a_start_floats: assert property (@(posedge i_clk) disable iff (i_srst)
    start_s && !ooe_s |=> !o_serial_out_oe) else $error("output kept after start bit");
  a_disabled_inert: assert property (@(posedge i_clk) disable iff (i_srst)
    st_r == ST_SETTLE && settle_r == SETTLE_LAST && !wen_r |=> st_r == ST_IDLE && !t_busy)
    else $error("write started without program enable");
  a_miscount_cancel: assert property (@(posedge i_clk) disable iff (i_srst)
    st_r == ST_SETTLE && settle_r == SETTLE_LAST && h_cnt_r != SHORT_CLKS
    && h_cnt_r != LONG_CLKS |=> st_r != ST_WRITING) else $error("miscounted frame wrote");
  a_low_disable: assert property (@(posedge i_clk) disable iff (i_srst)
    low_s |=> !wen_r ##1 !commit) else $error("enable kept under low supply");
  a_write_bound: assert property (@(posedge i_clk) disable iff (i_srst)
    busy_len_r <= WRITE_MAX_CYCLES) else $error("write period exceeds maximum");
  a_busy_no_start: assert property (@(posedge i_serial_clock) disable iff (!i_chip_select)
    busy_lk_r && !started_r |=> !started_r) else $error("start taken during write");
  a_reset_erased: assert property (@(posedge i_clk)
    $past(i_srst) |-> mem_r[0] == ERASED_WORD && wen_r == 1'b0) else $error("bad reset state");

endmodule

// *** tb/host_model.sv ***
/*
  Host side of the serial link: drives chip select, serial clock, serial in.
  Assumes a free reference clock; the serial clock is divided from it.
*/
`timescale 1ns/1ps
module host_model
(
  // reference
  input  wire logic i_ref_clk,
  // device pin
  input  wire logic i_dout,
  input  wire logic i_dout_oe,
  // link drive
  output logic      o_cs,
  output logic      o_sck,
  output logic      o_din
);
  // serial clock stands low outside frames
  initial
  begin
    o_cs  = 1'b0;
    o_sck = 1'b0;
    o_din = 1'b0;
  end

  // five reference clocks a half period: slow enough for read fetch
  task automatic half();
    repeat (5) @(posedge i_ref_clk);
  endtask

  // data set up before the rising clock, pin sampled late
  task automatic clk_bit(input logic b, output logic q);
    o_din <= b;
    half();
    o_sck <= 1'b1;
    half();
    q = i_dout_oe ? i_dout : 1'bz;
    o_sck <= 1'b0;
  endtask

  // callers start a frame only once the pin is high or floating
  task automatic send(input logic [31:0] v, input int n, output logic qf, output logic ql);
    o_cs <= 1'b1;
    half();
    for (int i = n - 1; i >= 0; i--)
    begin
      clk_bit(v[i], ql);
      if (i == n - 1)
        qf = ql;
    end
  endtask

  // shift one word out of the device
  task automatic get_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--)
      clk_bit(1'b0, w[i]);
  endtask

  // chip select low well beyond the deselect gap
  task automatic deselect();
    o_din <= 1'b0;
    o_cs  <= 1'b0;
    repeat (4) half();
  endtask

  // select with no clocks to watch write status
  task automatic select_idle();
    o_din <= 1'b0;
    o_cs  <= 1'b1;
  endtask
endmodule

// *** tb/tb_top.sv ***
/*
  Self-checking bench for the serial EEPROM command engine.
  Assumes the host model drives the link and a shortened write time.
*/
`timescale 1ns/1ps
module tb_top
  import eeprom_pkg::*;
;
  localparam int WCYC = 200;
  // clocks, reset, pins
  logic              i_clk;
  logic              ref_clk;
  logic              i_srst;
  logic              i_supply_low;
  logic              cs;
  logic              sck;
  logic              din;
  logic              dout;
  logic              dout_oe;
  // bench state
  int                mismatches;
  int                samples_checked;
  int                cycles;
  integer            seed;
  logic [15:0]       mem [MEM_WORDS];
  logic [ADDR_W-1:0] a;
  logic [15:0]       d;
  logic              qf;
  logic              ql;

  serial_eeprom_command_engine #(.WRITE_CYCLES(WCYC)) dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_serial_clock(sck), .i_chip_select(cs), .i_serial_in(din), .o_serial_out(dout),
    .o_serial_out_oe(dout_oe), .i_supply_low(i_supply_low));

  host_model u_host (.i_ref_clk(ref_clk), .i_dout(dout), .i_dout_oe(dout_oe),
    .o_cs(cs), .o_sck(sck), .o_din(din));

  // system clock, and an unrelated 12 ns link reference
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    ref_clk = 1'b0;
    #3.7;
    forever #6 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // frame bits: three leading zeros leave room for dummy clocks
  function automatic logic [31:0] frm(input logic [2:0] op, input logic [ADDR_W-1:0] ad,
                                      input logic [15:0] dt);
    return {3'h0, op, ad, dt};
  endfunction

  // read n words from ad; lead bit low, data, then float at deselect
  task automatic rd(input logic [ADDR_W-1:0] ad, input int n);
    logic [15:0] w;
    u_host.send(frm(3'h6, ad, 16'h0000) >> 16, 13, qf, ql);
    chk({15'h0000, qf}, {15'h0000, 1'bz});
    chk({15'h0000, ql}, 16'h0000);
    for (int k = 0; k < n; k++)
    begin
      u_host.get_word(w);
      chk(w, mem[ad + ADDR_W'(k)]);
    end
    u_host.deselect();
    chk({15'h0000, dout_oe}, 16'h0000);
  endtask

  // send a program or mode frame; poll status when a write should run
  task automatic cmd(input logic [31:0] v, input int n, input logic busy);
    int t;
    u_host.send(v, n, qf, ql);
    u_host.deselect();
    if (!busy)
      repeat (WCYC + 40) @(posedge i_clk);
    else
    begin
      u_host.select_idle();
      repeat (6) @(posedge i_clk);
      chk({14'h0000, dout_oe, dout}, 16'h0002);
      t = 0;
      while (dout !== 1'b1 && t < 1000)
      begin
        @(posedge i_clk);
        t++;
      end
      chk({15'h0000, t <= WCYC + 20}, 16'h0001);
      chk({14'h0000, dout_oe, dout}, 16'h0003);
      u_host.deselect();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h1315;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    i_srst = 1'b1;
    i_supply_low = 1'b0;
    for (int i = 0; i < MEM_WORDS; i++)
      mem[i] = ERASED_WORD;
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (5) @(posedge i_clk);
    // delivered contents, across the top address wrap
    rd(10'h3FF, 2);
    a = ADDR_W'($random(seed));
    d = 16'($random(seed));
    // program disable mode after reset: no change, no busy
    cmd(frm(3'h5, a, d), 29, 1'b0);
    rd(a, 1);
    cmd(frm(3'h4, 10'h300, 16'h0000) >> 16, 13, 1'b0);
    // single writes, the first padded with three dummy clocks
    for (int k = 0; k < 4; k++)
    begin
      a = ADDR_W'($random(seed));
      d = 16'($random(seed));
      cmd(frm(3'h5, a, d), (k == 0) ? 32 : 29, 1'b1);
      mem[a] = d;
      rd(a, 1);
    end
    // one clock too many, then one too few: both cancelled
    cmd(frm(3'h5, a, ~d) << 1, 30, 1'b0);
    cmd(frm(3'h5, a, ~d) >> 1, 28, 1'b0);
    rd(a, 1);
    cmd(frm(3'h7, a, 16'h0000) >> 16, 13, 1'b1);
    mem[a] = ERASED_WORD;
    rd(a, 1);
    d = 16'($random(seed));
    cmd(frm(3'h4, 10'h100, d), 29, 1'b1);
    for (int i = 0; i < MEM_WORDS; i++)
      mem[i] = d;
    rd(ADDR_W'($random(seed)), 2);
    cmd(frm(3'h4, 10'h200, 16'h0000) >> 16, 13, 1'b1);
    for (int i = 0; i < MEM_WORDS; i++)
      mem[i] = ERASED_WORD;
    rd(ADDR_W'($random(seed)), 2);
    // disable, then a write must leave the word alone
    cmd(frm(3'h4, 10'h000, 16'h0000) >> 16, 13, 1'b0);
    cmd(frm(3'h5, a, d), 29, 1'b0);
    rd(a, 1);
    // low supply clears program enable mode
    cmd(frm(3'h4, 10'h300, 16'h0000) >> 16, 13, 1'b0);
    @(posedge i_clk);
    i_supply_low <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_supply_low <= 1'b0;
    repeat (10) @(posedge i_clk);
    cmd(frm(3'h5, a, d), 29, 1'b0);
    rd(a, 1);
    end_sim();
  end
endmodule
